// ==== adcsp_host.sv ====
// Functional notes
// - Register access frame is 16 bits: command byte then data byte
// - Convert/select line held low for the whole register access frame
// - SDI changes on SCK fall, device samples on rise; SDO sampled before fall
// - First command bit is 0; next bit chooses write or read
// - Command bits 5..0 always sent as 0,1,0,1,0,0
// - No register reads issued in daisy-chain mode; such requests refused
// - Host may clock fewer status bits; all six in daisy-chain mode
// - SDI held high in conversion frames; convert rise starts conversion
// - Wait first quiet interval after convert rise before pulling line low
// - Second quiet interval between last SCK fall and convert rise
`timescale 1ns/10ps
`default_nettype none

module adcsp_host
    import adcsp_pkg::*;
#(
    parameter int SCK_HALF = 4
) (
    // Clock and reset
    input  wire  logic        clk,
    input  wire  logic        rst,
    // User command port
    input  wire  logic        startReq,
    input  wire  logic [1:0]  opSel,
    input  wire  logic [7:0]  wrData,
    input  wire  logic [2:0]  statusCnt,
    input  wire  logic        chainMode,
    output logic              busy,
    output logic              opRefused,
    output logic              done,
    // User results
    output logic [7:0]        rdData,
    output logic [15:0]       result,
    output logic [5:0]        status,
    output logic              clampOk,
    // Device pins
    output logic              convSel,
    output logic              sck,
    output logic              sdi,
    input  wire  logic        sdo
);

    adcsp_state_t state_reg, state_next;
    logic [1:0]   op_reg;
    logic         chain_reg;
    logic [2:0]   statCnt_reg;
    logic [4:0]   total_reg;
    logic [4:0]   bitCnt_reg;
    logic [7:0]   divCnt_reg;
    logic [15:0]  waitCnt_reg;
    logic [15:0]  tx_reg;
    logic [21:0]  rx_reg;
    logic         cnv_reg;
    logic         sck_reg;
    logic         sdi_reg;
    logic         done_reg;
    logic         refused_reg;
    logic [7:0]   rdData_reg;
    logic [15:0]  result_reg;
    logic [5:0]   status_reg;
    logic         clampOk_reg;
    logic         sdoMeta_reg;
    logic         sdoSync_reg;

    function automatic logic [5:0] alignStatus(input logic [21:0] raw, input logic [2:0] n);
        logic [5:0] s;
        s = raw[5:0];
        return s << (STATUS_BITS - n);
    endfunction : alignStatus

    function automatic logic [15:0] alignResult(input logic [21:0] raw, input logic [2:0] n);
        logic [21:0] t;
        t = raw >> n;
        return t[15:0];
    endfunction : alignResult

    wire        isIdle    = state_reg == ST_IDLE;
    wire        isShift   = state_reg == ST_SHIFT;
    wire        isConv    = op_reg == OP_CONV;
    wire        waitDone  = waitCnt_reg == 16'h0000;
    wire        phaseEnd  = divCnt_reg == 8'(SCK_HALF - 1);
    wire        sckRise   = isShift && phaseEnd && !sck_reg;
    wire        sckFall   = isShift && phaseEnd && sck_reg;
    wire [4:0]  bitCntInc = bitCnt_reg + 5'h01;
    wire        lastBit   = sckFall && (bitCntInc == total_reg);
    wire        badOp     = (chainMode && opSel == OP_READ) || opSel == 2'h3;
    wire        startOk   = startReq && isIdle && !badOp;
    wire [2:0]  statCap   = (statusCnt > STATUS_BITS) ? STATUS_BITS : statusCnt;
    wire [2:0]  statEff   = chainMode ? STATUS_BITS : statCap;
    wire [4:0]  startLen  = (opSel == OP_CONV) ? FRAME_LEN + {2'b00, statEff} : FRAME_LEN;
    wire        rwBit     = (opSel == OP_READ) ? CMD_RW_READ : CMD_RW_WR;
    wire [15:0] regWord   = {CMD_ENABLE, rwBit, CMD_FIXED, wrData};
    wire [15:0] startWord = (opSel == OP_CONV) ? 16'hFFFF : regWord;
    wire [15:0] txShifted = {tx_reg[14:0], 1'b1};
    wire [21:0] rxNext    = {rx_reg[20:0], sdoSync_reg};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (startOk) state_next = ST_WAIT1;
            ST_WAIT1: if (waitDone) state_next = ST_SHIFT;
            ST_SHIFT: if (lastBit) state_next = ST_WAIT2;
            ST_WAIT2: if (waitDone) state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    // SDO crosses in from the pin: meta stage feeds only the sync stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdoMeta_reg <= 1'b0;
            sdoSync_reg <= 1'b0;
        end else begin
            sdoMeta_reg <= sdo;
            sdoSync_reg <= sdoMeta_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            op_reg      <= OP_CONV;
            chain_reg   <= 1'b0;
            statCnt_reg <= 3'h0;
            total_reg   <= FRAME_LEN;
        end else begin
            state_reg <= state_next;
            if (startOk) begin
                op_reg      <= opSel;
                chain_reg   <= chainMode;
                statCnt_reg <= (opSel == OP_CONV) ? statEff : 3'h0;
                total_reg   <= startLen;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_reg <= 16'h0000;
        end else if (startOk) begin
            waitCnt_reg <= 16'(QUIET1_CYC - 1);
        end else if (lastBit) begin
            waitCnt_reg <= 16'(QUIET2_CYC - 1);
        end else if (!waitDone) begin
            waitCnt_reg <= waitCnt_reg - 16'h0001;
        end
    end

    // Half-period divider; SCK is made here, so no second domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= 8'h00;
        end else if (!isShift || phaseEnd) begin
            divCnt_reg <= 8'h00;
        end else begin
            divCnt_reg <= divCnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnv_reg <= 1'b1;
            sck_reg <= 1'b0;
            sdi_reg <= 1'b1;
        end else begin
            if (state_reg == ST_WAIT1 && waitDone) begin
                cnv_reg <= 1'b0;
                sdi_reg <= tx_reg[15];
            end else if (state_reg == ST_WAIT2 && waitDone) begin
                cnv_reg <= 1'b1;
            end
            if (sckRise) begin
                sck_reg <= 1'b1;
            end else if (sckFall) begin
                sck_reg <= 1'b0;
                sdi_reg <= lastBit ? 1'b1 : txShifted[15];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_reg     <= 16'hFFFF;
            rx_reg     <= 22'h000000;
            bitCnt_reg <= 5'h00;
        end else if (startOk) begin
            tx_reg     <= startWord;
            rx_reg     <= 22'h000000;
            bitCnt_reg <= 5'h00;
        end else if (sckFall) begin
            tx_reg     <= txShifted;
            rx_reg     <= rxNext;
            bitCnt_reg <= bitCntInc;
        end
    end

    // Results are captured at the last fall, before the quiet gap ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_reg  <= 8'h00;
            result_reg  <= 16'h0000;
            status_reg  <= 6'h00;
            clampOk_reg <= 1'b1;
        end else if (lastBit && isConv) begin
            result_reg <= alignResult(rxNext, statCnt_reg);
            status_reg <= alignStatus(rxNext, statCnt_reg);
            if (statCnt_reg != 3'h0) begin
                clampOk_reg <= rxNext[statCnt_reg - 3'h1];
            end
        end else if (lastBit && op_reg == OP_READ) begin
            rdData_reg  <= rxNext[7:0];
            clampOk_reg <= rxNext[CFG_CLAMP_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            done_reg    <= state_reg == ST_WAIT2 && waitDone;
            refused_reg <= startReq && isIdle && badOp;
        end
    end

    assign busy      = !isIdle;
    assign done      = done_reg;
    assign opRefused = refused_reg;
    assign rdData    = rdData_reg;
    assign result    = result_reg;
    assign status    = status_reg;
    assign clampOk   = clampOk_reg;
    assign convSel   = cnv_reg;
    assign sck       = sck_reg;
    assign sdi       = sdi_reg;

    // Helper gap counters, read only by assertions
    logic [15:0] sinceRise_reg;
    logic [15:0] sckLow_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sinceRise_reg <= 16'h0000;
            sckLow_reg    <= 16'hFFFF;
        end else begin
            sinceRise_reg <= !cnv_reg ? 16'h0000 :
                             (sinceRise_reg == 16'hFFFF) ? sinceRise_reg : sinceRise_reg + 16'h0001;
            sckLow_reg    <= sck_reg ? 16'h0000 :
                             (sckLow_reg == 16'hFFFF) ? sckLow_reg : sckLow_reg + 16'h0001;
        end
    end

    property p_frame16;
        @(posedge clk) disable iff (rst)
        (state_reg == ST_WAIT2 && !isConv) |-> bitCnt_reg == FRAME_LEN;
    endproperty
    a_frame16: assert property (p_frame16) else $error("register frame not 16 bits");

    property p_selLow;
        @(posedge clk) disable iff (rst)
        isShift |-> !cnv_reg;
    endproperty
    a_selLow: assert property (p_selLow) else $error("select high during shift");

    property p_sdiStable;
        @(posedge clk) disable iff (rst)
        (sck_reg && $past(sck_reg)) |-> $stable(sdi_reg);
    endproperty
    a_sdiStable: assert property (p_sdiStable) else $error("SDI moved while SCK high");

    property p_firstBit;
        @(posedge clk) disable iff (rst)
        ($fell(cnv_reg) && !isConv) |-> !sdi_reg;
    endproperty
    a_firstBit: assert property (p_firstBit) else $error("first command bit not 0");

    property p_pattern;
        @(posedge clk) disable iff (rst) (sckRise && !isConv && bitCnt_reg[4:3] == 2'h0 &&
            bitCnt_reg[2:1] != 2'h0) |-> sdi_reg == CMD_FIXED[3'h7 - bitCnt_reg[2:0]];
    endproperty
    a_pattern: assert property (p_pattern) else $error("command pattern wrong");

    property p_noChainRead;
        @(posedge clk) disable iff (rst)
        (startReq && isIdle && chainMode && opSel == OP_READ) |=> isIdle ##0 opRefused;
    endproperty
    a_noChainRead: assert property (p_noChainRead) else $error("chain read not refused");

    property p_chainSix;
        @(posedge clk) disable iff (rst)
        (isShift && isConv && chain_reg) |-> total_reg == FRAME_LEN + 5'h06;
    endproperty
    a_chainSix: assert property (p_chainSix) else $error("chain frame short of status");

    property p_sdiHigh;
        @(posedge clk) disable iff (rst)
        (isShift && isConv) |-> sdi_reg;
    endproperty
    a_sdiHigh: assert property (p_sdiHigh) else $error("SDI low in conversion frame");

    property p_quiet1;
        @(posedge clk) disable iff (rst)
        $fell(cnv_reg) |-> sinceRise_reg >= 16'(QUIET1_CYC);
    endproperty
    a_quiet1: assert property (p_quiet1) else $error("first quiet wait too short");

    property p_quiet2;
        @(posedge clk) disable iff (rst)
        $rose(cnv_reg) |-> sckLow_reg >= 16'(QUIET2_CYC);
    endproperty
    a_quiet2: assert property (p_quiet2) else $error("second quiet gap too short");

endmodule : adcsp_host

`default_nettype wire

// ==== adcsp_pkg.sv ====
package adcsp_pkg;

    // System clock
    localparam int CLK_PERIOD_PS  = 4000;

    // Quiet intervals, in ns
    localparam int QUIET1_NS      = 100;
    localparam int QUIET2_NS      = 60;

    // Least times round up to whole cycles
    localparam int QUIET1_CYC     = (QUIET1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int QUIET2_CYC     = (QUIET2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Frame sizes
    localparam int FRAME_BITS     = 16;
    localparam int RESULT_BITS    = 16;
    localparam int MAX_BITS       = 22;
    localparam logic [4:0] FRAME_LEN   = 5'h10;
    localparam logic [2:0] STATUS_BITS = 3'h6;

    // Register access command byte
    localparam logic       CMD_ENABLE  = 1'b0;
    localparam logic       CMD_RW_READ = 1'b1;
    localparam logic       CMD_RW_WR   = 1'b0;
    localparam logic [5:0] CMD_FIXED   = 6'h14;

    // Configuration register field positions
    localparam int CFG_CLAMP_BIT  = 0;
    localparam int CFG_TURBO_BIT  = 1;
    localparam int CFG_HIZ_BIT    = 2;
    localparam int CFG_SPAN_BIT   = 3;
    localparam int CFG_STAT_BIT   = 4;

    // Status word field positions
    localparam int ST_CLAMP_BIT   = 5;
    localparam int ST_SPAN_BIT    = 4;
    localparam int ST_HIZ_BIT     = 3;
    localparam int ST_TURBO_BIT   = 2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT1 = 4'h2,
        ST_SHIFT = 4'h4,
        ST_WAIT2 = 4'h8
    } adcsp_state_t;

    typedef enum logic [1:0] {
        OP_CONV  = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ  = 2'h2
    } adcsp_op_t;

endpackage : adcsp_pkg

// ==== adcsp_host_note_unused.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== adcsp_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module adcsp_dev_model
    import adcsp_pkg::*;
(
    // Device pins
    input  wire logic        convSel,
    input  wire logic        sck,
    input  wire logic        sdi,
    output logic             sdo,
    // Analog stand-ins
    input  wire logic        ovEvent,
    input  wire logic [15:0] sampleIn
);
    logic [7:0]  cfg_reg  = 8'h01;
    logic [7:0]  snap_reg = 8'h00;
    logic [15:0] sh_reg   = 16'h0000;
    logic [4:0]  rise_reg = 5'h00;
    logic [4:0]  fall_reg = 5'h00;
    logic [15:0] cur_reg  = 16'h0000;
    logic [15:0] prev_reg = 16'h0000;
    logic [21:0] word_reg = 22'h000000;
    logic        rd_reg   = 1'b0;
    logic        last_reg = 1'b0;
    wire  logic [7:0] cmdNow;
    wire  logic       sdoEn;
    wire  logic       bitNow;

    assign cmdNow = {sh_reg[6:0], sdi};
    always @(posedge sck or posedge convSel or posedge ovEvent) begin
        if (ovEvent)
            cfg_reg[CFG_CLAMP_BIT] <= 1'b0;
        if (convSel) begin
            rise_reg <= 5'h00;
            rd_reg <= 1'b0;
        end else begin
            sh_reg <= {sh_reg[14:0], sdi};
            rise_reg <= rise_reg + 5'h01;
            if (rise_reg == 5'h07) begin
                rd_reg <= (cmdNow == {CMD_ENABLE, CMD_RW_READ, CMD_FIXED});
                snap_reg <= cfg_reg;
            end
            if (rise_reg == 5'h0F && sh_reg[14:7] == {CMD_ENABLE, CMD_RW_WR, CMD_FIXED})
                cfg_reg[7:1] <= sh_reg[6:0];
            if (rise_reg == 5'h0F && rd_reg && !ovEvent)
                cfg_reg[CFG_CLAMP_BIT] <= 1'b1;
        end
    end
    always @(posedge convSel) begin
        prev_reg <= cur_reg;
        cur_reg <= sampleIn;
    end
    always @(negedge convSel)
        word_reg <= {cfg_reg[CFG_TURBO_BIT] ? prev_reg : cur_reg, cfg_reg[CFG_CLAMP_BIT],
                     cfg_reg[CFG_SPAN_BIT], cfg_reg[CFG_HIZ_BIT], cfg_reg[CFG_TURBO_BIT], 2'h0};
    assign sdoEn = !convSel && (fall_reg < (cfg_reg[CFG_STAT_BIT] ? 5'h16 : 5'h10));
    assign bitNow = (rd_reg && fall_reg[4:3] == 2'h1) ? snap_reg[3'h7 - fall_reg[2:0]]
                                                     : word_reg[5'h15 - fall_reg];
    // Released line toggles so a stale bit never passes
    assign sdo = sdoEn ? bitNow : ~last_reg;
    always @(negedge sck or posedge convSel) begin
        last_reg <= sdo;
        if (convSel)
            fall_reg <= 5'h00;
        else
            fall_reg <= fall_reg + 5'h01;
    end
endmodule : adcsp_dev_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench
    import adcsp_pkg::*;
;
    localparam int HALF = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        startReq = 1'b0;
    logic [1:0]  opSel = 2'h0;
    logic [7:0]  wrData = 8'h00;
    logic [2:0]  statusCnt = 3'h0;
    logic        chainMode = 1'b0;
    logic        ovEvent = 1'b0;
    logic [15:0] sampleIn = 16'h0000;
    logic        busy, opRefused, done, clampOk, convSel, sck, sdi, sdo;
    logic [7:0]  rdData;
    logic [15:0] result;
    logic [5:0]  status;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          sdiBad = 0;
    int          len = 0;

    adcsp_host #(.SCK_HALF(HALF)) uut (.clk(clk), .rst(rst), .startReq(startReq),
        .opSel(opSel), .wrData(wrData), .statusCnt(statusCnt), .chainMode(chainMode),
        .busy(busy), .opRefused(opRefused), .done(done), .rdData(rdData),
        .result(result), .status(status), .clampOk(clampOk), .convSel(convSel),
        .sck(sck), .sdi(sdi), .sdo(sdo));
    adcsp_dev_model devModel (.convSel(convSel), .sck(sck), .sdi(sdi), .sdo(sdo),
        .ovEvent(ovEvent), .sampleIn(sampleIn));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic int frameLen(input int n);
        return QUIET1_CYC + n * 2 * HALF + QUIET2_CYC;
    endfunction : frameLen

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic runOp(input logic [1:0] op, input logic [7:0] wd, input logic [2:0] sc,
                         input logic [15:0] smp, input logic ch);
        @(posedge clk);
        startReq <= 1'b1;
        opSel <= op;
        wrData <= wd;
        statusCnt <= sc;
        sampleIn <= smp;
        chainMode <= ch;
        @(posedge clk);
        startReq <= 1'b0;
        len = 0;
        do begin
            @(posedge clk);
            #1;
            len++;
        end while (done !== 1'b1 && len < 400);
        check({13'h0, done, convSel, busy}, 16'h0006); // frame closed by rise
    endtask : runOp

    task automatic refuse(input logic [1:0] op, input logic ch);
        @(posedge clk);
        startReq <= 1'b1;
        opSel <= op;
        chainMode <= ch;
        @(posedge clk);
        startReq <= 1'b0;
        #1;
        check({13'h0, opRefused, convSel, busy}, 16'h0006); // refused, pins still
    endtask : refuse

    // Conversion frames keep SDI up
    always @(posedge sck)
        if (opSel == OP_CONV && busy && sdi !== 1'b1)
            sdiBad++;

    // Run is about 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({11'h0, convSel, sck, sdi, busy, clampOk}, 16'h0015); // idle levels
        $display("test reset done");
        runOp(OP_READ, 8'h01, 3'h0, 16'h1111, 1'b0);
        check(16'(len), 16'(frameLen(16))); // frame timing
        check({8'h0, rdData}, 16'h0001); // reset contents
        runOp(OP_WRITE, 8'h1E, 3'h0, 16'hA5C3, 1'b0);
        runOp(OP_READ, 8'h01, 3'h0, 16'h3C5A, 1'b0);
        check({8'h0, rdData}, 16'h001F); // write read back
        $display("test register done");
        runOp(OP_CONV, 8'h00, 3'h7, 16'h0F0F, 1'b0);
        check(16'(len), 16'(frameLen(22))); // full status frame
        check(result, 16'hA5C3); // older result
        check({10'h0, status}, 16'h003C); // status word
        runOp(OP_CONV, 8'h00, 3'h3, 16'h1234, 1'b0);
        check(result, 16'h3C5A); // turbo readout
        check({10'h0, status}, 16'h0038); // partial status
        runOp(OP_CONV, 8'h00, 3'h2, 16'h4321, 1'b1);
        check(16'(len), 16'(frameLen(22))); // chain takes all six
        check({10'h0, status}, 16'h003C); // chain status
        $display("test turbo done");
        runOp(OP_WRITE, 8'h00, 3'h0, 16'h5555, 1'b0);
        runOp(OP_CONV, 8'h00, 3'h0, 16'h6666, 1'b0);
        check(16'(len), 16'(frameLen(16))); // result only
        check(result, 16'h5555); // latest result
        $display("test normal done");
        @(posedge clk);
        ovEvent <= 1'b1;
        runOp(OP_READ, 8'h01, 3'h0, 16'h7777, 1'b0);
        check({7'h0, clampOk, rdData}, 16'h0000); // flag low
        @(posedge clk);
        ovEvent <= 1'b0;
        runOp(OP_READ, 8'h01, 3'h0, 16'h7777, 1'b0);
        check({7'h0, clampOk, rdData}, 16'h0000); // still held
        runOp(OP_READ, 8'h01, 3'h0, 16'h7777, 1'b0);
        check({7'h0, clampOk, rdData}, 16'h0101); // cleared by read
        $display("test clamp done");
        refuse(2'h3, 1'b0);
        refuse(OP_READ, 1'b1);
        check(16'(sdiBad), 16'h0000); // SDI high in conversions
        $display("test refuse done");
        results();
    end
endmodule : testbench
`default_nettype wire
